/* File: core/sfp_pkg.sv */
// Behaviour
// - Pause entered when pause pin low and serial clock low.
// - Pause left when pause pin high coincides with serial clock low.
// - While paused, output released and clock and data ignored, position kept.
// - Deselect during pause resets interface; resume needs pause high, select low.
// - Status write refused when protect pin low and lock bit set.
// - Bit 0 shows an erase or program in progress; read-only, zero at start.
// - Bit 1 shows the write enable latch; read-only, zero at start.
// - Bits 2 to 4 hold protection level, all ones at start.
// - Bit 6 shows auto-increment programming mode; read-only, zero at start.
// - Bit 7 lock, writable, zero at start; when set and protect pin low, level bits frozen.
// - Status write data loads only level bits and lock; bit 5 reads zero.
// - All status bits are volatile and return to defaults on power-up.
// - Program and erase refused while write enable latch is clear.
// - Latch clears on disable, completions, top address and any status write.
// - Instruction starts at select fall; data sampled on rising clock, MSB first.
// - Every opcode, address or data byte is exactly eight clocks.
// - Deselect before a byte's last bit aborts to standby.
// - Protection level selects protected upper region; protected writes rejected.
// - Full erase runs only with all level bits zero.
// - Output bits change on falling serial clock.
package sfp_pkg;

    localparam int unsigned BYTE_BITS = 8;

    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] OP_STATUS_READ   = 8'h05;
    localparam logic [7:0] OP_BYTE_PROGRAM  = 8'h02;
    localparam logic [7:0] OP_AUTO_PROGRAM  = 8'had;
    localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE   = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hc7;

    // Bytes needed, opcode included, before deselect executes
    localparam logic [2:0] LEN_SHORT   = 3'h1;
    localparam logic [2:0] LEN_STATUS  = 3'h2;
    localparam logic [2:0] LEN_ERASE   = 3'h4;
    localparam logic [2:0] LEN_PROGRAM = 3'h5;
    localparam logic [2:0] LEN_AUTO    = 3'h6;
    localparam logic [2:0] LEN_MAX     = 3'h7;
    localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
    localparam logic [2:0] IDX_DATA      = 3'h4;

    localparam int unsigned ST_BUSY_BIT  = 0;
    localparam int unsigned ST_WEL_BIT   = 1;
    localparam int unsigned ST_LEVEL_LSB = 2;
    localparam int unsigned ST_LEVEL_MSB = 4;
    localparam int unsigned ST_RSVD_BIT  = 5;
    localparam int unsigned ST_AUTO_BIT  = 6;
    localparam int unsigned ST_LOCK_BIT  = 7;

    localparam logic       RST_WEL   = 1'b0;
    localparam logic [2:0] RST_LEVEL = 3'h7;
    localparam logic       RST_LOCK  = 1'b0;

    typedef enum logic [2:0] {
        REQ_BYTE_PROGRAM = 3'b000,
        REQ_AUTO_PROGRAM = 3'b001,
        REQ_SECTOR_ERASE = 3'b010,
        REQ_BLOCK_ERASE  = 3'b011,
        REQ_CHIP_ERASE   = 3'b100
    } sfp_req_t;

    typedef enum logic {
        BUS_STANDBY  = 1'b0,
        BUS_SELECTED = 1'b1
    } sfp_bus_t;

endpackage

/* File: core/sfp_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module sfp_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1  <= '1;
            syncOut <= '1;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule
`default_nettype wire

/* File: core/sfp_front_end.sv */
`timescale 1ns/1ns
`default_nettype none
module sfp_front_end (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Serial pins
    input  wire logic        sckPin,
    input  wire logic        csNPin,
    input  wire logic        siPin,
    input  wire logic        holdNPin,
    input  wire logic        wpNPin,
    output logic             soOut,
    output logic             soOe,
    // Engine status
    input  wire logic        engineBusy,
    input  wire logic        engineDone,
    input  wire logic        autoMode,
    input  wire logic        autoTopReached,
    // Engine requests
    output logic             reqValid,
    output sfp_pkg::sfp_req_t reqKind,
    output logic      [23:0] reqAddr,
    output logic      [7:0]  reqData,
    // Observation
    output logic             holdActive,
    output logic      [7:0]  statusView
);

    logic [4:0] syncBus;
    logic       sckS;
    logic       csS;
    logic       siS;
    logic       holdS;
    logic       wpS;

    sfp_sync #(
        .WIDTH (5)
    ) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  ({sckPin, csNPin, siPin, holdNPin, wpNPin}),
        .syncOut  (syncBus)
    );

    assign {sckS, csS, siS, holdS, wpS} = syncBus;

    function automatic logic inProtected(input logic [2:0] level, input logic [23:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (level)
            3'h0:    hit = 1'b0;
            3'h1:    hit = (addr[18:16] == 3'h7);
            3'h2:    hit = (addr[18:17] == 2'h3);
            3'h3:    hit = addr[18];
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // Status byte value held in reset
    localparam logic [7:0] RST_VIEW = {sfp_pkg::RST_LOCK, 1'b0, 1'b0, sfp_pkg::RST_LEVEL,
                                       sfp_pkg::RST_WEL, 1'b0};

    // Status byte assembled from its fields
    function automatic logic [7:0] packStatus(input logic       lockBit,
                                              input logic       autoBit,
                                              input logic [2:0] levelBits,
                                              input logic       welBit,
                                              input logic       busyBit);
        logic [7:0] stByte;
        stByte = 8'h00;
        stByte[sfp_pkg::ST_BUSY_BIT] = busyBit;
        stByte[sfp_pkg::ST_WEL_BIT] = welBit;
        stByte[sfp_pkg::ST_LEVEL_MSB:sfp_pkg::ST_LEVEL_LSB] = levelBits;
        stByte[sfp_pkg::ST_RSVD_BIT] = 1'b0;
        stByte[sfp_pkg::ST_AUTO_BIT] = autoBit;
        stByte[sfp_pkg::ST_LOCK_BIT] = lockBit;
        return stByte;
    endfunction

    sfp_pkg::sfp_bus_t busState;
    sfp_pkg::sfp_bus_t next_busState;
    logic        sckPrev;
    logic        paused;
    logic        next_paused;
    logic [2:0]  bitCnt;
    logic [2:0]  next_bitCnt;
    logic [2:0]  byteIdx;
    logic [2:0]  next_byteIdx;
    logic [6:0]  shiftReg;
    logic [6:0]  next_shiftReg;
    logic [7:0]  opcode;
    logic [7:0]  next_opcode;
    logic [23:0] addrReg;
    logic [23:0] next_addrReg;
    logic [7:0]  dataReg;
    logic [7:0]  next_dataReg;
    logic        write_enable_latch;
    logic        next_wel;
    logic [2:0]  level;
    logic [2:0]  next_level;
    logic        lock;
    logic        next_lock;
    logic        next_soOut;
    logic        next_soOe;
    logic        next_reqValid;
    sfp_pkg::sfp_req_t next_reqKind;
    logic [7:0]  statusByte;
    logic        sckRise;
    logic        sckFall;
    logic [7:0]  inByte;
    logic        reading;
    logic        mayWrite;

    assign statusByte = packStatus(lock, autoMode, level, write_enable_latch, engineBusy);
    assign sckRise    = sckS & ~sckPrev & ~paused;
    assign sckFall    = ~sckS & sckPrev & ~paused;
    assign inByte     = {shiftReg, siS};
    assign reading    = (opcode == sfp_pkg::OP_STATUS_READ) && (byteIdx != 3'h0);
    assign mayWrite   = write_enable_latch && !engineBusy;

    // Pause tracking
    always_comb begin
        next_paused = paused;
        if (paused) begin
            if (holdS && !sckS && !csS) begin
                next_paused = 1'b0;
            end
        end else if (!holdS && !sckS && !csS && busState == sfp_pkg::BUS_SELECTED) begin
            next_paused = 1'b1;
        end
    end

    // Framing, execution and status
    always_comb begin
        next_busState = busState;
        next_bitCnt   = bitCnt;
        next_byteIdx  = byteIdx;
        next_shiftReg = shiftReg;
        next_opcode   = opcode;
        next_addrReg  = addrReg;
        next_dataReg  = dataReg;
        next_wel      = write_enable_latch;
        next_level    = level;
        next_lock     = lock;
        next_soOut    = soOut;
        next_reqValid = 1'b0;
        next_reqKind  = reqKind;
        if (engineDone || autoTopReached) begin
            next_wel = 1'b0;
        end
        unique case (busState)
            sfp_pkg::BUS_STANDBY: begin
                if (!csS) begin
                    next_busState = sfp_pkg::BUS_SELECTED;
                    next_bitCnt   = 3'h0;
                    next_byteIdx  = 3'h0;
                    next_opcode   = 8'h00;
                end
            end
            sfp_pkg::BUS_SELECTED: begin
                if (csS) begin
                    next_busState = sfp_pkg::BUS_STANDBY;
                    next_bitCnt   = 3'h0;
                    next_byteIdx  = 3'h0;
                    // Partial byte or deselect while paused: drop it
                    if (bitCnt == 3'h0 && !paused) begin
                        unique case (opcode)
                            sfp_pkg::OP_WRITE_ENABLE: begin
                                if (!engineBusy && byteIdx >= sfp_pkg::LEN_SHORT) begin
                                    next_wel = 1'b1;
                                end
                            end
                            sfp_pkg::OP_WRITE_DISABLE: begin
                                if (!engineBusy && byteIdx >= sfp_pkg::LEN_SHORT) begin
                                    next_wel = 1'b0;
                                end
                            end
                            sfp_pkg::OP_STATUS_WRITE: begin
                                if (!engineBusy && byteIdx >= sfp_pkg::LEN_STATUS) begin
                                    next_wel = 1'b0;
                                    if (wpS || !lock) begin
                                        next_level = dataReg[sfp_pkg::ST_LEVEL_MSB:
                                                             sfp_pkg::ST_LEVEL_LSB];
                                        next_lock  = dataReg[sfp_pkg::ST_LOCK_BIT];
                                    end
                                end
                            end
                            sfp_pkg::OP_BYTE_PROGRAM: begin
                                if (mayWrite && byteIdx >= sfp_pkg::LEN_PROGRAM
                                    && !inProtected(level, addrReg)) begin
                                    next_reqValid = 1'b1;
                                    next_reqKind  = sfp_pkg::REQ_BYTE_PROGRAM;
                                end
                            end
                            sfp_pkg::OP_AUTO_PROGRAM: begin
                                if (mayWrite && byteIdx >= sfp_pkg::LEN_AUTO
                                    && !inProtected(level, addrReg)) begin
                                    next_reqValid = 1'b1;
                                    next_reqKind  = sfp_pkg::REQ_AUTO_PROGRAM;
                                end
                            end
                            sfp_pkg::OP_SECTOR_ERASE: begin
                                if (mayWrite && byteIdx >= sfp_pkg::LEN_ERASE
                                    && !inProtected(level, addrReg)) begin
                                    next_reqValid = 1'b1;
                                    next_reqKind  = sfp_pkg::REQ_SECTOR_ERASE;
                                end
                            end
                            sfp_pkg::OP_BLOCK_ERASE: begin
                                if (mayWrite && byteIdx >= sfp_pkg::LEN_ERASE
                                    && !inProtected(level, addrReg)) begin
                                    next_reqValid = 1'b1;
                                    next_reqKind  = sfp_pkg::REQ_BLOCK_ERASE;
                                end
                            end
                            sfp_pkg::OP_CHIP_ERASE_A, sfp_pkg::OP_CHIP_ERASE_B: begin
                                if (mayWrite && byteIdx >= sfp_pkg::LEN_SHORT
                                    && level == 3'h0) begin
                                    next_reqValid = 1'b1;
                                    next_reqKind  = sfp_pkg::REQ_CHIP_ERASE;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end else begin
                    if (sckRise) begin
                        next_shiftReg = inByte[6:0];
                        next_bitCnt   = bitCnt + 3'h1;
                        if (bitCnt == 3'(sfp_pkg::BYTE_BITS - 1)) begin
                            if (byteIdx == 3'h0) begin
                                next_opcode = inByte;
                            end else if (byteIdx <= sfp_pkg::IDX_ADDR_LAST) begin
                                next_addrReg = {addrReg[15:0], inByte};
                            end
                            if ((byteIdx == 3'h1 && opcode == sfp_pkg::OP_STATUS_WRITE)
                                || byteIdx == sfp_pkg::IDX_DATA) begin
                                next_dataReg = inByte;
                            end
                            if (byteIdx != sfp_pkg::LEN_MAX) begin
                                next_byteIdx = byteIdx + 3'h1;
                            end
                        end
                    end
                    if (sckFall && reading) begin
                        next_soOut = statusByte[~bitCnt];
                    end
                end
            end
        endcase
        next_soOe = (next_busState == sfp_pkg::BUS_SELECTED) && !csS
                    && !next_paused && reading;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busState   <= sfp_pkg::BUS_STANDBY;
            sckPrev    <= 1'b1;
            paused     <= 1'b0;
            bitCnt     <= 3'h0;
            byteIdx    <= 3'h0;
            shiftReg   <= 7'h00;
            opcode     <= 8'h00;
            addrReg    <= 24'h000000;
            dataReg    <= 8'h00;
            write_enable_latch        <= sfp_pkg::RST_WEL;
            level      <= sfp_pkg::RST_LEVEL;
            lock       <= sfp_pkg::RST_LOCK;
            soOut      <= 1'b0;
            soOe       <= 1'b0;
            reqValid   <= 1'b0;
            reqKind    <= sfp_pkg::REQ_BYTE_PROGRAM;
            reqAddr    <= 24'h000000;
            reqData    <= 8'h00;
            holdActive <= 1'b0;
            statusView <= RST_VIEW;
        end else begin
            busState   <= next_busState;
            sckPrev    <= sckS;
            paused     <= next_paused;
            bitCnt     <= next_bitCnt;
            byteIdx    <= next_byteIdx;
            shiftReg   <= next_shiftReg;
            opcode     <= next_opcode;
            addrReg    <= next_addrReg;
            dataReg    <= next_dataReg;
            write_enable_latch        <= next_wel;
            level      <= next_level;
            lock       <= next_lock;
            soOut      <= next_soOut;
            soOe       <= next_soOe;
            reqValid   <= next_reqValid;
            reqKind    <= next_reqKind;
            reqAddr    <= next_reqValid ? addrReg : reqAddr;
            reqData    <= next_reqValid ? dataReg : reqData;
            holdActive <= next_paused;
            statusView <= packStatus(next_lock, autoMode, next_level, next_wel, engineBusy);
        end
    end

endmodule
`default_nettype wire

/* File: testbench/sfp_front_end_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module sfp_front_end_chk (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              sys_rst,
    // Serial pins
    input wire logic              sckPin,
    input wire logic              csNPin,
    input wire logic              siPin,
    input wire logic              holdNPin,
    input wire logic              wpNPin,
    input wire logic              soOut,
    input wire logic              soOe,
    // Engine
    input wire logic              engineBusy,
    input wire logic              engineDone,
    input wire logic              autoMode,
    input wire logic              autoTopReached,
    input wire logic              reqValid,
    input wire sfp_pkg::sfp_req_t reqKind,
    input wire logic [23:0]       reqAddr,
    input wire logic [7:0]        reqData,
    // Observation
    input wire logic              holdActive,
    input wire logic [7:0]        statusView
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Selected, clock low, pause pin at the given level
    sequence s_sel_low(logic p);
        (p && !sckPin && !csNPin)[*8];
    endsequence
    chk_hold_entry: assert property (s_sel_low(!holdNPin) |-> holdActive)
        else $error("pause not entered");
    chk_hold_exit: assert property (s_sel_low(holdNPin) |-> !holdActive)
        else $error("pause not left");
    chk_hold_release: assert property (holdActive ##1 holdActive |-> !soOe)
        else $error("output driven in pause");
    chk_rsvd_zero: assert property (statusView[5] == 1'b0)
        else $error("reserved bit set");
    chk_busy_track: assert property (1'b1 |=> statusView[0] == $past(engineBusy))
        else $error("busy bit wrong");
    chk_auto_track: assert property (1'b1 |=> statusView[6] == $past(autoMode))
        else $error("auto bit wrong");
    chk_req_wel: assert property (reqValid |-> $past(statusView[1]))
        else $error("request without latch");
    chk_chip_level: assert property (
        reqValid && reqKind == sfp_pkg::REQ_CHIP_ERASE |-> $past(statusView[4:2]) == 3'h0)
        else $error("chip erase while protected");
    chk_done_clear: assert property (engineDone |=> !statusView[1])
        else $error("latch kept after done");
    chk_level_lock: assert property (
        (!wpNPin && statusView[7])[*6] |-> $stable(statusView[4:2]))
        else $error("locked level changed");
endmodule
bind sfp_front_end sfp_front_end_chk u_chk (.*);
`default_nettype wire

/* File: testbench/sfp_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sfp_host_model (
    // Clock
    input  wire logic core_clk,
    // Serial pins
    output var logic  sckPin,
    output var logic  csNPin,
    output var logic  siPin,
    output var logic  holdNPin,
    output var logic  wpNPin,
    input  wire logic soOut,
    input  wire logic soOe
);
    initial begin
        sckPin = 1'b0;
        csNPin = 1'b1;
        siPin = 1'b0;
        holdNPin = 1'b1;
        wpNPin = 1'b1;
    end
    // Half of the 80 ns link period
    task automatic half();
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic start();
        csNPin = 1'b0;
        half();
    endtask
    task automatic stop();
        half();
        csNPin = 1'b1;
        siPin = ~siPin;
        half();
        half();
    endtask
    // Sends n bits MSB first, sampling the output before each rise
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            siPin = tx[i];
            half();
            rx = {rx[6:0], soOe ? soOut : 1'bz};
            sckPin = 1'b1;
            half();
            sckPin = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: testbench/sfp_front_end_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sfp_front_end_tb_top;
    logic              core_clk, sys_rst, sckPin, csNPin, siPin, holdNPin, wpNPin;
    logic              soOut, soOe, engineBusy, engineDone, autoMode, autoTopReached;
    logic              reqValid, holdActive;
    sfp_pkg::sfp_req_t reqKind;
    logic [23:0]       reqAddr;
    logic [7:0]        reqData, statusView;
    int                failures, compares, nReq, nb;
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    sfp_front_end u_dut (.*);
    sfp_host_model u_host (.*);
    always @(posedge core_clk) if (reqValid === 1'b1) nReq <= nReq + 1;
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        tick();
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
        tick();
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [39:0] tail, input int n);
        logic [7:0] r;
        u_host.start();
        u_host.shift(op, 8, r);
        for (int k = n - 1; k >= 0; k--)
            u_host.shift(tail[8*k +: 8], 8, r);
        u_host.stop();
    endtask
    task automatic st_chk(input logic [7:0] exp);
        logic [7:0] a, b, r;
        u_host.start();
        u_host.shift(sfp_pkg::OP_STATUS_READ, 8, r);
        u_host.shift(8'h00, 8, a);
        u_host.shift(8'h00, 8, b);
        u_host.stop();
        chk("status byte", exp, a);
        chk("status repeat", exp, b);
        chk("statusView", exp, statusView);
    endtask
    task automatic t_program();
        cmd(sfp_pkg::OP_STATUS_WRITE, 32'h63, 1);
        st_chk(8'h00);
        nb = nReq;
        cmd(sfp_pkg::OP_BYTE_PROGRAM, 32'h012345a5, 4);
        chk("refused program", nb, nReq);
        cmd(sfp_pkg::OP_WRITE_ENABLE, 0, 0);
        chk("wel set", 1, statusView[1]);
        cmd(sfp_pkg::OP_BYTE_PROGRAM, 32'h012345a5, 4);
        chk("req count", nb + 1, nReq);
        chk("req kind", sfp_pkg::REQ_BYTE_PROGRAM, reqKind);
        chk("req addr", 24'h012345, reqAddr);
        chk("req data", 8'ha5, reqData);
        cmd(sfp_pkg::OP_WRITE_ENABLE, 0, 0);
        cmd(sfp_pkg::OP_SECTOR_ERASE, 32'h031000, 3);
        chk("sector kind", sfp_pkg::REQ_SECTOR_ERASE, reqKind);
        chk("sector addr", 24'h031000, reqAddr);
        cmd(sfp_pkg::OP_WRITE_ENABLE, 0, 0);
        cmd(sfp_pkg::OP_BLOCK_ERASE, 32'h040000, 3);
        chk("block kind", sfp_pkg::REQ_BLOCK_ERASE, reqKind);
        cmd(sfp_pkg::OP_WRITE_ENABLE, 0, 0);
        cmd(sfp_pkg::OP_AUTO_PROGRAM, 40'h0500007e81, 5);
        chk("auto kind", sfp_pkg::REQ_AUTO_PROGRAM, reqKind);
        chk("auto data", 8'h7e, reqData);
        chk("kinds count", nb + 4, nReq);
        pulse(engineDone);
        chk("wel after done", 0, statusView[1]);
    endtask
    task automatic t_protect();
        cmd(sfp_pkg::OP_STATUS_WRITE, 32'h88, 1);
        st_chk(8'h88);
        cmd(sfp_pkg::OP_WRITE_ENABLE, 0, 0);
        nb = nReq;
        cmd(sfp_pkg::OP_BYTE_PROGRAM, 32'h07000011, 4);
        cmd(sfp_pkg::OP_CHIP_ERASE_A, 0, 0);
        chk("protected refused", nb, nReq);
        cmd(sfp_pkg::OP_BYTE_PROGRAM, 32'h05ffff3c, 4);
        chk("open accepted", nb + 1, nReq);
        u_host.wpNPin = 1'b0;
        cmd(sfp_pkg::OP_STATUS_WRITE, 32'h00, 1);
        st_chk(8'h88);
        u_host.wpNPin = 1'b1;
        cmd(sfp_pkg::OP_STATUS_WRITE, 32'h00, 1);
        st_chk(8'h00);
        cmd(sfp_pkg::OP_WRITE_ENABLE, 0, 0);
        cmd(sfp_pkg::OP_CHIP_ERASE_B, 0, 0);
        chk("chip erase", sfp_pkg::REQ_CHIP_ERASE, reqKind);
        chk("chip count", nb + 2, nReq);
    endtask
    task automatic t_abort();
        logic [7:0] r;
        cmd(sfp_pkg::OP_WRITE_DISABLE, 0, 0);
        st_chk(8'h00);
        u_host.start();
        u_host.shift(sfp_pkg::OP_WRITE_ENABLE, 7, r);
        u_host.stop();
        chk("short opcode", 0, statusView[1]);
        u_host.start();
        u_host.shift(sfp_pkg::OP_WRITE_ENABLE, 8, r);
        u_host.shift(8'h00, 3, r);
        u_host.stop();
        chk("partial byte", 0, statusView[1]);
    endtask
    task automatic t_busy();
        tick();
        engineBusy = 1'b1;
        autoMode = 1'b1;
        st_chk(8'h41);
        engineBusy = 1'b0;
        autoMode = 1'b0;
        cmd(sfp_pkg::OP_WRITE_ENABLE, 0, 0);
        pulse(autoTopReached);
        chk("wel after top", 0, statusView[1]);
    endtask
    task automatic t_hold();
        logic [7:0] a, b, r;
        cmd(sfp_pkg::OP_WRITE_ENABLE, 0, 0);
        u_host.start();
        u_host.shift(sfp_pkg::OP_STATUS_READ, 8, r);
        u_host.shift(8'h00, 3, a);
        u_host.holdNPin = 1'b0;
        u_host.half();
        u_host.half();
        chk("paused", 1, holdActive);
        chk("so released", 0, soOe);
        u_host.shift(8'hff, 2, r);
        u_host.holdNPin = 1'b1;
        u_host.half();
        u_host.half();
        chk("resumed", 0, holdActive);
        u_host.shift(8'h00, 5, b);
        u_host.stop();
        chk("paused byte", 8'h02, {a[2:0], b[4:0]});
        u_host.start();
        u_host.shift(sfp_pkg::OP_WRITE_DISABLE, 8, r);
        u_host.holdNPin = 1'b0;
        u_host.half();
        u_host.csNPin = 1'b1;
        u_host.half();
        u_host.half();
        chk("pause kept", 1, holdActive);
        u_host.holdNPin = 1'b1;
        u_host.csNPin = 1'b0;
        u_host.half();
        chk("resumed again", 0, holdActive);
        u_host.stop();
        chk("no execute", 1, statusView[1]);
    endtask
    task automatic t_reset();
        cmd(sfp_pkg::OP_STATUS_WRITE, 32'h94, 1);
        st_chk(8'h94);
        tick();
        sys_rst = 1'b1;
        repeat (20) tick();
        sys_rst = 1'b0;
        repeat (3) tick();
        st_chk(8'h1c);
    endtask
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        engineBusy = 1'b0;
        engineDone = 1'b0;
        autoMode = 1'b0;
        autoTopReached = 1'b0;
        failures = 0;
        compares = 0;
        nReq = 0;
        repeat (20) tick();
        sys_rst = 1'b0;
        repeat (3) tick();
        st_chk(8'h1c);
        t_program();
        t_protect();
        t_abort();
        t_busy();
        t_hold();
        t_reset();
        close_out();
    end
    initial begin
        #400000;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
